// *** pcc_per_channel_ctrl.v ***
// What this block does
// R1: A controller with its stream enable at 0 drives no control stream.
// R2: Enable at 1 starts the stream, read from the control store.
// R3: Host fills all 72 locations with streams disabled before enabling.
// R4: Reset selects direct access: the indirect select bit comes up 0.
// R5: Host sets indirect select in both controllers after every reset.
// R6: With indirect select at 1, store access uses buffer and address reg.
// R7: Busy reads 1 while a request is processed, 0 once it completes.
// R8: Host checks busy is 0 before starting any indirect access.
// R9: Indirect write: host loads buffer, then address reg with flag 0.
// R10: Writing the address register sets busy at once until access ends.
// R11: Flag 1 read loads the location into the buffer; host reads later.
// R12: Host polls busy down to 0 before reading or the next request.
// R13: A finished write stores the buffer at the addressed location only.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`include "pcc_defs.vh"
`default_nettype none

module pcc_per_channel_ctrl (
  input  wire       i_ref_clk,
  input  wire       i_rst_n,
  input  wire       i_wb_cyc,
  input  wire       i_wb_stb,
  input  wire       i_wb_we,
  input  wire [7:0] i_wb_adr,
  input  wire [7:0] i_wb_dat,
  input  wire       i_wb_sel,
  output wire       o_wb_ack,
  output wire [7:0] o_wb_dat,
  input  wire [6:0] i_tx_chan_idx,
  input  wire [6:0] i_rx_chan_idx,
  output wire [7:0] o_tx_ctrl_stream,
  output wire [7:0] o_rx_ctrl_stream
);

  reg  [7:0] store_r [0:`PCC_STORE_DEPTH-1];
  reg  [1:0] cfg_r   [0:1];
  reg  [7:0] buf_r   [0:1];
  reg  [7:0] ac_r    [0:1];
  reg        busy_r  [0:1];
  reg  [1:0] cnt_r   [0:1];
  reg  [7:0] strm_r  [0:1];
  reg        ack_r;
  reg  [7:0] rdat_r;
  reg  [7:0] rdat_nxt;
  integer    c;

  // Flat store index of a channel in one controller
  function [7:0] store_idx;
    input       ctl;
    input [6:0] chan;
    begin
      store_idx = (ctl ? `PCC_LOCATIONS : 8'h00) + {1'b0, chan};
    end
  endfunction

  function chan_ok;
    input [6:0] chan;
    begin
      chan_ok = ({1'b0, chan} < `PCC_LOCATIONS);
    end
  endfunction

  wire       req    = i_wb_cyc & i_wb_stb & ~ack_r;
  wire       wr_acc = req & i_wb_we & i_wb_sel;
  wire       sel_c  = i_wb_adr[2];
  wire [1:0] reg_sel = i_wb_adr[1:0];
  wire       mapped = (i_wb_adr[7:3] == 5'h00);

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;
  assign o_tx_ctrl_stream = strm_r[0];
  assign o_rx_ctrl_stream = strm_r[1];

  always @* begin
    rdat_nxt = 8'h00;
    if (mapped) begin
      case (reg_sel)
        2'h0: rdat_nxt = {6'h00, cfg_r[sel_c]};
        2'h1: rdat_nxt = {busy_r[sel_c], 7'h00}; // R7
        2'h2: rdat_nxt = ac_r[sel_c];
        2'h3: rdat_nxt = buf_r[sel_c];
        default: rdat_nxt = 8'h00;
      endcase
    end
  end

  // Registers answer one cycle after the request; unmapped reads give 0
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_r  <= 1'b0;
      rdat_r <= 8'h00;
    end else begin
      ack_r  <= req;
      rdat_r <= req ? rdat_nxt : 8'h00;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (c = 0; c < 2; c = c + 1) begin
        cfg_r[c]  <= `PCC_CFG_RESET; // R4
        buf_r[c]  <= 8'h00;
        ac_r[c]   <= 8'h00;
        busy_r[c] <= 1'b0;
        cnt_r[c]  <= 2'h0;
      end
    end else begin
      for (c = 0; c < 2; c = c + 1) begin
        if (wr_acc && mapped && sel_c == c[0]) begin
          if (reg_sel == 2'h0)
            cfg_r[c] <= i_wb_dat[1:0];
          // Buffer is frozen while a request is in flight
          if (reg_sel == 2'h3 && !busy_r[c])
            buf_r[c] <= i_wb_dat;
        end
        if (busy_r[c]) begin
          if (cnt_r[c] == 2'h1) begin
            busy_r[c] <= 1'b0; // R7
            cnt_r[c]  <= 2'h0;
            if (ac_r[c][`PCC_AC_RNW_BIT]) begin
              if (chan_ok(ac_r[c][`PCC_AC_CHAN_MSB:0]))
                buf_r[c] <= store_r[store_idx(c[0],
                              ac_r[c][`PCC_AC_CHAN_MSB:0])]; // R11
              else
                buf_r[c] <= 8'h00;
            end
          end else begin
            cnt_r[c] <= cnt_r[c] - 2'h1;
          end
        end else if (wr_acc && mapped && sel_c == c[0] &&
                     reg_sel == 2'h2 &&
                     cfg_r[c][`PCC_CFG_INDIRECT_BIT]) begin // R6
          ac_r[c]   <= i_wb_dat;
          busy_r[c] <= 1'b1; // R10
          cnt_r[c]  <= `PCC_ACCESS_CYCLES;
        end
      end
    end
  end

  // Store has no reset; software fills it before enabling the streams
  always @(posedge i_ref_clk) begin
    for (c = 0; c < 2; c = c + 1) begin
      if (busy_r[c] && cnt_r[c] == 2'h1 &&
          !ac_r[c][`PCC_AC_RNW_BIT] &&
          chan_ok(ac_r[c][`PCC_AC_CHAN_MSB:0]))
        store_r[store_idx(c[0], ac_r[c][`PCC_AC_CHAN_MSB:0])]
          <= buf_r[c]; // R13
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strm_r[0] <= 8'h00;
      strm_r[1] <= 8'h00;
    end else begin
      if (cfg_r[0][`PCC_CFG_ENABLE_BIT] && chan_ok(i_tx_chan_idx))
        strm_r[0] <= store_r[store_idx(1'b0, i_tx_chan_idx)]; // R2
      else
        strm_r[0] <= 8'h00; // R1
      if (cfg_r[1][`PCC_CFG_ENABLE_BIT] && chan_ok(i_rx_chan_idx))
        strm_r[1] <= store_r[store_idx(1'b1, i_rx_chan_idx)]; // R2
      else
        strm_r[1] <= 8'h00; // R1
    end
  end

endmodule

`default_nettype wire

// *** pcc_defs.vh ***
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH

// Byte offsets of the registers, one register per offset
`define PCC_OFF_TX_CFG     8'h00
`define PCC_OFF_TX_STAT    8'h01
`define PCC_OFF_TX_ADDR    8'h02
`define PCC_OFF_TX_DATA    8'h03
`define PCC_OFF_RX_CFG     8'h04
`define PCC_OFF_RX_STAT    8'h05
`define PCC_OFF_RX_ADDR    8'h06
`define PCC_OFF_RX_DATA    8'h07

// Configuration register fields
`define PCC_CFG_ENABLE_BIT   0
`define PCC_CFG_INDIRECT_BIT 1
`define PCC_CFG_RESET        2'h0

// Status register field
`define PCC_STAT_BUSY_BIT    7

// Address/control register fields
`define PCC_AC_RNW_BIT       7
`define PCC_AC_CHAN_MSB      6

// Control store geometry
`define PCC_LOCATIONS        8'h48
`define PCC_STORE_DEPTH      144

// Cycles a store access stays busy after the request is taken
`define PCC_ACCESS_CYCLES    2'h2

`endif

// *** pcc_per_channel_ctrl_monitor.sv ***
`default_nettype none
module pcc_ctrl_monitor (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       i_wb_cyc,
  input wire logic       i_wb_stb,
  input wire logic       i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [7:0] i_wb_dat,
  input wire logic       i_wb_sel,
  input wire logic       o_wb_ack,
  input wire logic [7:0] o_wb_dat,
  input wire logic [6:0] i_tx_chan_idx,
  input wire logic [6:0] i_rx_chan_idx,
  input wire logic [7:0] o_tx_ctrl_stream,
  input wire logic [7:0] o_rx_ctrl_stream
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic       take;
  logic       wr;
  logic       rd;
  logic [7:0] tcfg_r;
  logic [7:0] rcfg_r;
  assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = take & i_wb_we & i_wb_sel;
  assign rd = take & ~i_wb_we;
  // Shadow of both config registers, as the host wrote them
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tcfg_r <= 8'h00;
      rcfg_r <= 8'h00;
    end else if (wr && i_wb_adr == 8'h00) begin
      tcfg_r <= i_wb_dat;
    end else if (wr && i_wb_adr == 8'h04) begin
      rcfg_r <= i_wb_dat;
    end
  end
  a_ack_follows: assert property (take |=> o_wb_ack) else $error("no ack");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 8'h00)
    else $error("read data outside ack");
  a_tx_quiet: assert property (!tcfg_r[0] |=> o_tx_ctrl_stream == 8'h00)
    else $error("tx stream while off");
  a_rx_quiet: assert property (!rcfg_r[0] |=> o_rx_ctrl_stream == 8'h00)
    else $error("rx stream while off");
  a_range_quiet: assert property (i_tx_chan_idx > 7'h47 |=>
    o_tx_ctrl_stream == 8'h00) else $error("stream past last channel");
  a_cfg_reads: assert property (rd && i_wb_adr == 8'h00 |=>
    o_wb_dat[1:0] == tcfg_r[1:0]) else $error("config read wrong");
  a_hole_zero: assert property (rd && i_wb_adr > 8'h07 |=>
    o_wb_dat == 8'h00) else $error("unmapped read not zero");
  cover property (rd && i_wb_adr == 8'h07);
  cover property (wr && i_wb_adr == 8'h02);
  cover property (tcfg_r[0] && o_tx_ctrl_stream != 8'h00);
endmodule
bind pcc_per_channel_ctrl pcc_ctrl_monitor pcc_ctrl_monitor_inst (.*);
`default_nettype wire

// *** pcc_host_model.sv ***
`default_nettype none
module pcc_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_wb_ack,
  input  wire logic [7:0] i_wb_dat,
  output var  logic [2:0] o_wb_ctl,
  output var  logic [7:0] o_wb_adr,
  output var  logic [7:0] o_wb_dat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_wb_ctl = 3'h0;
  // Control is cyc, stb, we; released data flips so stale values show
  task bus(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_ref_clk);
    o_wb_ctl <= {2'h3, w};
    o_wb_adr <= a;
    o_wb_dat <= d;
    do @(posedge i_ref_clk); while (i_wb_ack !== 1'h1);
    q = i_wb_dat;
    o_wb_ctl <= 3'h0;
    o_wb_dat <= ~d;
  endtask
endmodule
`default_nettype wire

// *** test_per_channel_ctrl_indirect_access.sv ***
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module test_per_channel_ctrl_indirect_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       ack;
  logic [2:0] ctl;
  logic [6:0] tx_idx = 7'h00;
  logic [6:0] rx_idx = 7'h00;
  logic [7:0] adr, wdat, rdat, q, tx_s, rx_s;
  logic [7:0] mem [2][72];
  int         fail_count = 0, checked = 0, cyc_n = 0, i, j, k;
  always #2.5 clk = ~clk;
  pcc_per_channel_ctrl pcc_per_channel_ctrl_inst (.i_ref_clk(clk),
    .i_rst_n(rst_n), .i_wb_cyc(ctl[2]), .i_wb_stb(ctl[1]), .i_wb_we(ctl[0]),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(1'h1), .o_wb_ack(ack),
    .o_wb_dat(rdat), .i_tx_chan_idx(tx_idx), .i_rx_chan_idx(rx_idx),
    .o_tx_ctrl_stream(tx_s), .o_rx_ctrl_stream(rx_s));
  pcc_host_model pcc_host_model_inst (.i_ref_clk(clk), .i_wb_ack(ack),
    .i_wb_dat(rdat), .o_wb_ctl(ctl), .o_wb_adr(adr), .o_wb_dat(wdat));
  task summarize;
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc_n == 20000) begin
    fail_count++;
    summarize;
  end
  function logic [7:0] sexp(int c, int x);
    return x < 72 ? mem[c][x] : 8'h00;
  endfunction
  task h(input logic w, input logic [7:0] a, d);
    pcc_host_model_inst.bus(w, a, d, q);
  endtask
  task poll(input logic [7:0] b);
    int n;
    n = 0;
    do begin h(0, b + 8'h01, 0); n++; end while (q[7] !== 1'h0 && n < 16);
    `CHK("busy", 1'h0, q[7])
  endtask
  task acc(input logic [7:0] b, input logic w, input logic [6:0] ch,
           input logic [7:0] d);
    poll(b);
    if (w) h(1, b + 8'h03, d);
    h(1, b + 8'h02, {~w, ch});
    poll(b);
    if (!w) h(0, b + 8'h03, 0);
  endtask
  initial begin
    void'($urandom(32'h07907276));
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    for (i = 0; i < 2; i++) begin
      h(0, 8'(i * 4), 0); `CHK("cfg", 8'h00, q)
      h(1, 8'(i * 4 + 2), 8'h05); h(0, 8'(i * 4 + 2), 0); `CHK("ac", 8'h00, q)
      h(1, 8'(i * 4), 8'h02);
      for (j = 0; j < 72; j++) begin
        mem[i][j] = $urandom;
        acc(8'(i * 4), 1, 7'(j), mem[i][j]);
      end
    end
    for (j = 0; j < 30; j++) begin
      if (j == 4) begin h(1, 8'h00, 8'h03); h(1, 8'h04, 8'h03); end
      k = j == 1 ? 72 : $urandom_range(71);
      tx_idx <= 7'(k);
      rx_idx <= 7'(k ^ 1);
      repeat (2) @(posedge clk);
      `CHK("tx", j < 4 ? 8'h00 : sexp(0, k), tx_s)
      `CHK("rx", j < 4 ? 8'h00 : sexp(1, k ^ 1), rx_s)
      i = $urandom_range(1);
      if (j % 3 == 0) begin mem[i][k % 72] = $urandom;
        acc(8'(i * 4), 1, 7'(k % 72), mem[i][k % 72]); end
      else begin acc(8'(i * 4), 0, 7'(k % 72), 0);
        `CHK("buf", mem[i][k % 72], q) end
    end
    h(1, 8'h00, 8'h01); acc(8'h00, 1, 7'h03, ~mem[0][3]); h(1, 8'h00, 8'h03);
    acc(8'h00, 0, 7'h03, 0); `CHK("direct", mem[0][3], q)
    h(0, 8'h3C, 0); `CHK("hole", 8'h00, q)
    rst_n <= 1'h0; repeat (2) @(posedge clk); rst_n <= 1'h1;
    h(0, 8'h04, 0); `CHK("cfg2", 8'h00, q)
    summarize;
  end
endmodule
`default_nettype wire
